// ===== hdl/mie_exec.sv
`timescale 1ns/1ps
// execution unit for page moves, halt, subtract and nibble exchange
// How it works
// RULE1: page read copies entry into wreg
// RULE2: page write loads wreg into entry
// RULE3: halt clears watchdog counter and divider
// RULE4: halt sets expiry flag, clears halt flag
// RULE5: after halt, core stops executing
// RULE6: subtract gives file minus wreg
// RULE7: destination bit picks wreg or file
// RULE8: subtract updates zero, half carry, carry
// RULE9: exchange swaps high and low nibbles
// RULE10: one cycle each; exchange keeps flags
module mie_exec (
	input  wire logic                    i_mclk,
	input  wire logic                    i_resetn,
	input  wire mie_pkg::mie_op_t        i_op,
	input  wire logic [3:0]              i_page_index,
	input  wire logic [5:0]              i_file_addr,
	input  wire logic                    i_dest,
	input  wire logic                    i_wake,
	input  wire logic                    i_wdt_tick,
	input  wire logic                    i_file_load,
	input  wire logic [7:0]              i_file_data,
	output logic      [7:0]              o_working_register,
	output logic                         o_zero_flag,
	output logic                         o_half_carry_flag,
	output logic                         o_carry_flag,
	output logic                         o_expiry_flag_n,
	output logic                         o_halt_entered_n,
	output logic      [7:0]              o_watchdog_counter,
	output logic      [7:0]              o_watchdog_divider,
	output logic                         o_halted,
	output logic                         o_done
);
	typedef struct packed {
		mie_pkg::mie_state_t                     state;
		logic [7:0]                              wreg;
		logic                                    zf;
		logic                                    hcf;
		logic                                    cf;
		logic                                    exp_n;
		logic                                    halt_n;
		logic [7:0]                              wdt;
		logic [7:0]                              div;
		logic                                    done;
		logic                                    halted;
		logic [mie_pkg::PAGE_DEPTH-1:0][7:0]     page;
		logic [mie_pkg::FILE_DEPTH-1:0][7:0]     file;
	} mie_state_reg_t;

	mie_state_reg_t st;
	mie_state_reg_t next_st;
	logic [7:0]     file_val;
	logic [7:0]     diff;
	logic [7:0]     swapped;
	logic           d_zero;
	logic           d_half;
	logic           d_carry;
	logic           take;
	logic           do_read;
	logic           do_write;
	logic           do_halt;
	logic           do_sub;
	logic           do_nib;
	logic           file_we;
	logic [7:0]     file_wdata;
	logic           page_we;

	logic [mie_pkg::FILE_DEPTH-1:0] file_hit;
	logic [mie_pkg::PAGE_DEPTH-1:0] page_hit;

	assign file_val = st.file[i_file_addr];

	mie_alu u_alu (
		.i_file_val        (file_val),
		.i_wreg            (st.wreg),
		.o_diff            (diff),
		.o_diff_zero       (d_zero),
		.o_diff_half_carry (d_half),
		.o_diff_carry      (d_carry),
		.o_swapped         (swapped)
	);

	// per-entry address match; storage below is written entry by entry
	for (genvar g_ent = 0; g_ent < mie_pkg::FILE_DEPTH; g_ent++) begin : g_entry
		assign file_hit[g_ent] = (int'(i_file_addr) == g_ent);
		if (g_ent < mie_pkg::PAGE_DEPTH) begin : g_page
			assign page_hit[g_ent] = (int'(i_page_index) == g_ent);
		end
	end

	// decode of the op taken this edge; nothing is taken while halted
	always_comb begin
		do_read  = 1'b0;
		do_write = 1'b0;
		do_halt  = 1'b0;
		do_sub   = 1'b0;
		do_nib   = 1'b0;
		if (st.state == mie_pkg::ST_RUN) begin
			case (i_op)
				mie_pkg::OP_SPECIAL_PAGE_READ: begin
					do_read = 1'b1;
				end
				mie_pkg::OP_SPECIAL_PAGE_WRITE: begin
					do_write = 1'b1;
				end
				mie_pkg::OP_HALT: begin
					do_halt = 1'b1;
				end
				mie_pkg::OP_SUBTRACT_FROM_FILE: begin
					do_sub = 1'b1;
				end
				mie_pkg::OP_NIBBLE_EXCHANGE: begin
					do_nib = 1'b1;
				end
				default: begin
					do_read = 1'b0;
				end
			endcase
		end
		take = do_read | do_write | do_halt | do_sub | do_nib;
	end

	// RULE7: file write port, shared by load and write-back
	always_comb begin
		file_we    = 1'b0;
		file_wdata = i_file_data;
		page_we    = do_write;
		// stands in for the core's other file writers, so results can be seeded
		if ((st.state == mie_pkg::ST_RUN) && i_file_load) begin
			file_we = 1'b1;
		end
		// write-back wins over a same-cycle load of the same entry
		if ((do_sub || do_nib) && (i_dest == mie_pkg::DEST_FILE)) begin
			file_we    = 1'b1;
			file_wdata = do_sub ? diff : swapped;
		end
	end

	always_comb begin
		next_st      = st;
		// RULE10: single cycle issue, one done pulse
		next_st.done = take;
		// free-running divider and counter; left to the watchdog owner otherwise
		if (i_wdt_tick) begin
			next_st.div = st.div + 8'h01;
			if (st.div == mie_pkg::DIV_LAST) begin
				next_st.wdt = st.wdt + 8'h01;
			end
		end
		// RULE1: page to wreg
		if (do_read) begin
			next_st.wreg = st.page[i_page_index];
		end
		// RULE2: wreg to page
		for (int e = 0; e < mie_pkg::PAGE_DEPTH; e++) begin
			if (page_we && page_hit[e]) begin
				next_st.page[e] = st.wreg;
			end
		end
		// RULE7: result back to the file
		for (int e = 0; e < mie_pkg::FILE_DEPTH; e++) begin
			if (file_we && file_hit[e]) begin
				next_st.file[e] = file_wdata;
			end
		end
		if (do_halt) begin
			// RULE3: clear watchdog
			next_st.wdt = mie_pkg::WDT_CLEAR;
			next_st.div = mie_pkg::DIV_CLEAR;
			// RULE4: reset cause flags
			next_st.exp_n  = mie_pkg::HALT_SET_EXPIRY_N;
			next_st.halt_n = mie_pkg::HALT_SET_HALT_N;
		end
		if (do_sub) begin
			// RULE8: subtract flags
			next_st.zf  = d_zero;
			next_st.hcf = d_half;
			next_st.cf  = d_carry;
		end
		// RULE7: result to wreg when dest is 0
		if ((do_sub || do_nib) && (i_dest == mie_pkg::DEST_WREG)) begin
			next_st.wreg = do_sub ? diff : swapped;
		end
		case (st.state)
			mie_pkg::ST_RUN: begin
				// RULE5: enter halt
				if (do_halt) begin
					next_st.state  = mie_pkg::ST_HALTED;
					next_st.halted = 1'b1;
				end
			end
			mie_pkg::ST_HALTED: begin
				// RULE5: ignore ops until wake
				if (i_wake) begin
					next_st.state  = mie_pkg::ST_RUN;
					next_st.halted = 1'b0;
				end
			end
			default: begin
				next_st.state  = mie_pkg::ST_RUN;
				next_st.halted = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= '0;
			st.exp_n  <= mie_pkg::EXPIRY_N_RESET;
			st.halt_n <= mie_pkg::HALT_N_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign o_working_register = st.wreg;
	assign o_zero_flag        = st.zf;
	assign o_half_carry_flag  = st.hcf;
	assign o_carry_flag       = st.cf;
	assign o_expiry_flag_n    = st.exp_n;
	assign o_halt_entered_n   = st.halt_n;
	assign o_watchdog_counter = st.wdt;
	assign o_watchdog_divider = st.div;
	assign o_halted           = st.halted;
	assign o_done             = st.done;
endmodule : mie_exec

// ===== common/mie_pkg.sv
// shared constants and types for the five-instruction execution block
package mie_pkg;
	localparam int DATA_W      = 8;
	localparam int FILE_AW     = 6;
	localparam int FILE_DEPTH  = 64;
	localparam int PAGE_AW     = 4;
	localparam int PAGE_DEPTH  = 16;
	localparam int WDT_W       = 8;
	localparam int NIB_LO      = 3;
	localparam int NIB_HI      = 7;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam logic [7:0] WREG_RESET = 8'h00;
	localparam logic [7:0] WDT_CLEAR  = 8'h00;
	localparam logic [7:0] DIV_CLEAR  = 8'h00;
	localparam logic [7:0] DIV_LAST   = 8'hFF;
	localparam logic       EXPIRY_N_RESET = 1'h1;
	localparam logic       HALT_N_RESET   = 1'h1;
	localparam logic       HALT_SET_EXPIRY_N = 1'h1;
	localparam logic       HALT_SET_HALT_N   = 1'h0;
	localparam logic       DEST_WREG  = 1'h0;
	localparam logic       DEST_FILE  = 1'h1;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SPECIAL_PAGE_READ,
		OP_SPECIAL_PAGE_WRITE,
		OP_HALT,
		OP_SUBTRACT_FROM_FILE,
		OP_NIBBLE_EXCHANGE
	} mie_op_t;

	typedef enum logic [0:0] {
		ST_RUN,
		ST_HALTED
	} mie_state_t;
endpackage : mie_pkg

// ===== hdl/mie_alu.sv
`timescale 1ns/1ps
// combinational subtract and nibble exchange with flag results
module mie_alu (
	input  wire logic [7:0] i_file_val,
	input  wire logic [7:0] i_wreg,
	output logic      [7:0] o_diff,
	output logic            o_diff_zero,
	output logic            o_diff_half_carry,
	output logic            o_diff_carry,
	output logic      [7:0] o_swapped
);
	logic [8:0] sum;
	logic [4:0] low_sum;

	// RULE6: file minus wreg
	// computed as r + ~w + 1 so carry reads as no-borrow
	assign sum     = {1'b0, i_file_val} + {1'b0, ~i_wreg} + 9'h001;
	assign low_sum = {1'b0, i_file_val[mie_pkg::NIB_LO:0]} + {1'b0, ~i_wreg[mie_pkg::NIB_LO:0]}
		+ 5'h01;
	assign o_diff  = sum[7:0];
	// RULE8: flag results
	assign o_diff_zero       = (sum[7:0] == mie_pkg::ZERO_BYTE);
	assign o_diff_half_carry = low_sum[4];
	assign o_diff_carry      = sum[8];
	// RULE9: nibble swap
	assign o_swapped = {i_file_val[mie_pkg::NIB_LO:0],
		i_file_val[mie_pkg::NIB_HI:mie_pkg::NIB_LO+1]};
endmodule : mie_alu

// ===== dv/mie_exec_properties.sv
// port assertions for the execution block
`timescale 1ns/1ps
module mie_exec_properties (
	input wire logic             i_mclk,
	input wire logic             i_resetn,
	input wire mie_pkg::mie_op_t i_op,
	input wire logic             i_dest,
	input wire logic             i_wake,
	input wire logic [7:0]       o_working_register,
	input wire logic             o_zero_flag,
	input wire logic             o_half_carry_flag,
	input wire logic             o_carry_flag,
	input wire logic             o_expiry_flag_n,
	input wire logic             o_halt_entered_n,
	input wire logic [7:0]       o_watchdog_counter,
	input wire logic [7:0]       o_watchdog_divider,
	input wire logic             o_halted,
	input wire logic             o_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	wire logic [2:0] flg = {o_zero_flag, o_half_carry_flag, o_carry_flag};
	sequence s_go;
		!o_halted && i_op != mie_pkg::OP_NONE;
	endsequence
	sequence s_halt;
		s_go ##0 i_op == mie_pkg::OP_HALT;
	endsequence
	AST_DONE: assert property (s_go |=> o_done)
		else $error("op gave no done pulse");
	AST_HALT_WDT: assert property (s_halt |=> !(|{o_watchdog_counter, o_watchdog_divider}))
		else $error("halt left watchdog running");
	AST_HALT_FLG: assert property (s_halt |=> o_expiry_flag_n && !o_halt_entered_n && $stable(flg))
		else $error("halt flags wrong");
	AST_STAY: assert property (o_halted && !i_wake |=> o_halted)
		else $error("left halt without wake");
	AST_IDLE: assert property (o_halted |=> !o_done)
		else $error("op ran while halted");
	AST_PAGE: assert property (s_go ##0 i_op inside {mie_pkg::OP_SPECIAL_PAGE_READ, mie_pkg::OP_SPECIAL_PAGE_WRITE} |=> $stable(flg))
		else $error("page move touched flags");
	AST_SWAP: assert property (s_go ##0 i_op == mie_pkg::OP_NIBBLE_EXCHANGE |=> $stable(flg))
		else $error("exchange touched flags");
	AST_DEST: assert property (s_go ##0 i_op inside {mie_pkg::OP_SUBTRACT_FROM_FILE, mie_pkg::OP_NIBBLE_EXCHANGE} && i_dest |=> $stable(o_working_register))
		else $error("file result hit wreg");
	AST_SUB_Z: assert property (s_go ##0 i_op == mie_pkg::OP_SUBTRACT_FROM_FILE && !i_dest |=> o_zero_flag == (o_working_register == 8'h00))
		else $error("zero flag wrong");
endmodule : mie_exec_properties

// ===== dv/tb.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
module tb;
	logic i_mclk = 0, i_resetn = 0, i_dest = 0, i_wake = 0, i_wdt_tick = 0;
	mie_pkg::mie_op_t i_op = mie_pkg::OP_NONE;
	logic [3:0] i_page_index = 4'h0;
	logic [5:0] i_file_addr = 6'h00;
	logic i_file_load = 0;
	logic [7:0] i_file_data = 8'h00;
	logic [7:0] o_working_register, o_watchdog_counter, o_watchdog_divider, w, fl[64], pg[16];
	logic o_zero_flag, o_half_carry_flag, o_carry_flag, o_expiry_flag_n, o_halt_entered_n;
	logic o_halted, o_done, z = 0, h = 0, c = 0;
	logic [15:0] wd = 16'h0000;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	mie_exec i_dut (.i_mclk, .i_resetn, .i_op, .i_page_index, .i_file_addr, .i_dest, .i_wake,
		.i_wdt_tick, .i_file_load, .i_file_data, .o_working_register, .o_zero_flag,
		.o_half_carry_flag, .o_carry_flag, .o_expiry_flag_n, .o_halt_entered_n,
		.o_watchdog_counter, .o_watchdog_divider, .o_halted, .o_done);
	initial begin
		forever #5 i_mclk = ~i_mclk;
	end
	// zero, no borrow from bit 3, no borrow from bit 7, then the difference
	function automatic logic [10:0] f_sub(input logic [7:0] f, input logic [7:0] a);
		return {(f - a) == 8'h00, f[3:0] >= a[3:0], f >= a, 8'(f - a)};
	endfunction : f_sub
	function automatic logic [7:0] f_swap(input logic [7:0] f);
		return {f[3:0], f[7:4]};
	endfunction : f_swap
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic step(input mie_pkg::mie_op_t o, input logic [3:0] k, input logic [5:0] a,
		input logic d, input logic t, input logic ld, input logic [7:0] v);
		logic [7:0] f;
		logic [7:0] r;
		{i_op, i_page_index, i_file_addr, i_dest, i_wdt_tick, i_file_load, i_file_data} =
			{o, k, a, d, t, ld, v};
		f = fl[a];
		r = f_swap(f);
		@(posedge i_mclk);
		#1;
		// halt clear wins over a same-cycle tick
		wd = (o == mie_pkg::OP_HALT) ? 16'h0000 : wd + 16'(t);
		// load first; a write-back of the op to the same entry wins
		if (ld) fl[a] = v;
		if (o == mie_pkg::OP_SPECIAL_PAGE_READ) w = pg[k];
		if (o == mie_pkg::OP_SPECIAL_PAGE_WRITE) pg[k] = w;
		if (o == mie_pkg::OP_SUBTRACT_FROM_FILE) {z, h, c, r} = f_sub(f, w);
		if (o inside {mie_pkg::OP_SUBTRACT_FROM_FILE, mie_pkg::OP_NIBBLE_EXCHANGE}) begin
			if (d) fl[a] = r;
			else w = r;
		end
		chk(o_working_register, w);
		chk({o_zero_flag, o_half_carry_flag, o_carry_flag}, {z, h, c});
		chk({o_watchdog_counter, o_watchdog_divider}, wd);
		chk(o_done, o != mie_pkg::OP_NONE);
		if (o == mie_pkg::OP_HALT) begin
			chk({o_expiry_flag_n, o_halt_entered_n, o_halted}, 3'h5);
			// ops and loads offered while halted must both be ignored
			{i_op, i_wdt_tick, i_file_data} = {mie_pkg::OP_SUBTRACT_FROM_FILE, 1'b0, ~v};
			@(posedge i_mclk);
			#1;
			chk({o_done, o_halted, o_working_register}, {2'b01, w});
			{i_op, i_wake} = {mie_pkg::OP_NONE, 1'b1};
			@(posedge i_mclk);
			#1;
			i_wake = 0;
			chk(o_halted, 1'b0);
		end
	endtask : step
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	always @(posedge i_mclk) begin
		cyc++;
		// long enough for about 1100 cycles of tests
		if (cyc > 5000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	initial begin
		foreach (fl[i]) fl[i] = 8'h00;
		foreach (pg[i]) pg[i] = 8'h00;
		w = 8'h00;
		void'($urandom(32'h2751));
		repeat (5) @(posedge i_mclk);
		#1 i_resetn = 1;
		// idle ticks long enough to wrap the divider, then halt on a tick
		repeat (300) step(mie_pkg::OP_NONE, 4'hF, 6'h3F, 1'b1, 1'b1, 1'b0, 8'h00);
		step(mie_pkg::OP_HALT, 4'hF, 6'h3F, 1'b1, 1'b1, 1'b1, 8'h77);
		// worked subtract and swap cases, one load colliding with a write-back
		step(mie_pkg::OP_NONE, 4'h0, 6'h05, 1'b0, 1'b0, 1'b1, 8'h06);
		step(mie_pkg::OP_SUBTRACT_FROM_FILE, 4'h0, 6'h05, 1'b0, 1'b0, 1'b1, 8'h05);
		step(mie_pkg::OP_SUBTRACT_FROM_FILE, 4'h0, 6'h05, 1'b1, 1'b0, 1'b1, 8'h33);
		step(mie_pkg::OP_NONE, 4'h0, 6'h07, 1'b0, 1'b0, 1'b1, 8'hA5);
		step(mie_pkg::OP_NIBBLE_EXCHANGE, 4'h3, 6'h07, 1'b0, 1'b0, 1'b0, 8'h00);
		step(mie_pkg::OP_SPECIAL_PAGE_WRITE, 4'h3, 6'h07, 1'b0, 1'b0, 1'b0, 8'h00);
		step(mie_pkg::OP_SUBTRACT_FROM_FILE, 4'h3, 6'h07, 1'b0, 1'b0, 1'b0, 8'h00);
		step(mie_pkg::OP_SPECIAL_PAGE_READ, 4'h3, 6'h07, 1'b0, 1'b0, 1'b0, 8'h00);
		$display("test corner done");
		repeat (600) step(mie_pkg::mie_op_t'($urandom % 6), 4'($urandom), 6'($urandom),
			1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom));
		$display("test random done");
		report_and_stop;
	end
endmodule : tb
bind mie_exec mie_exec_properties i_props (.i_mclk, .i_resetn, .i_op, .i_dest, .i_wake,
	.o_working_register, .o_zero_flag, .o_half_carry_flag, .o_carry_flag, .o_expiry_flag_n,
	.o_halt_entered_n, .o_watchdog_counter, .o_watchdog_divider, .o_halted, .o_done);
